// ### rtl/asc_pkg.sv
// Package of constants and types for the asynchronous memory bus host
package asc_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // Timing figures in ns
    localparam int T_RC_NS = 70;
    localparam int T_AA_NS = 70;
    localparam int T_DOE_NS = 35;
    localparam int T_HZOE_NS = 25;
    localparam int T_HZWE_NS = 25;
    localparam int T_WC_NS = 70;
    localparam int T_PWE_NS = 50;
    localparam int T_SCE_NS = 60;
    localparam int T_AW_NS = 60;
    localparam int T_SD_NS = 30;
    // Least times round up to whole cycles
    localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OE_CYC = (T_DOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SD_CYC = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_MIN = (T_SCE_NS > T_PWE_NS) ? T_SCE_NS : T_PWE_NS;
    localparam int WP_NS0 = (T_AW_NS > WP_MIN) ? T_AW_NS : WP_MIN;
    localparam int WP_NS1 = (T_HZWE_NS + T_SD_NS > WP_NS0)
                            ? T_HZWE_NS + T_SD_NS : WP_NS0;
    localparam int WR_CYC = (WP_NS1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;
    // Reset value of the select, write strobe and gate pins
    localparam logic PIN_IDLE = 1'b1;

    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_RD_ADDR,
        ASC_RD_WAIT,
        ASC_WR_SETUP,
        ASC_WR_PULSE,
        ASC_WR_END,
        ASC_TURN
    } asc_state_t;
endpackage

// ### rtl/asc_sync.sv
// Two-flop synchroniser for a bus of pin inputs
module asc_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    // Next values: first stage feeds only the second
    always_comb begin
        next_stage1 = i_async;
        next_stage2 = stage1;
    end

    // Register both stages
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_sync = stage2;
endmodule

// ### rtl/asc_host.sv
// Host controller driving an asynchronous static memory bus
module asc_host #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // User request port
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic [DATA_W-1:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_standby,
    // Memory pins
    output logic o_chip_select_n,
    output logic o_write_strobe_n,
    output logic o_output_gate_n,
    output logic [ADDR_W-1:0] o_addr,
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data,
    output logic o_data_oe
);
    asc_pkg::asc_state_t state;
    asc_pkg::asc_state_t next_state;
    logic [asc_pkg::CNT_W-1:0] cnt;
    logic [asc_pkg::CNT_W-1:0] next_cnt;
    logic [asc_pkg::CNT_W-1:0] cyc;
    logic [asc_pkg::CNT_W-1:0] next_cyc;
    logic cs_n;
    logic next_cs_n;
    logic we_n;
    logic next_we_n;
    logic oe_n;
    logic next_oe_n;
    logic drive;
    logic next_drive;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [DATA_W-1:0] data_sync;

    localparam logic [asc_pkg::CNT_W-1:0] RD_N =
        asc_pkg::CNT_W'(asc_pkg::RD_CYC);
    localparam logic [asc_pkg::CNT_W-1:0] WR_N =
        asc_pkg::CNT_W'(asc_pkg::WR_CYC);
    localparam logic [asc_pkg::CNT_W-1:0] HZ_N =
        asc_pkg::CNT_W'(asc_pkg::HZ_CYC);
    localparam logic [asc_pkg::CNT_W-1:0] WC_N =
        asc_pkg::CNT_W'(asc_pkg::WC_CYC);
    localparam logic [asc_pkg::CNT_W-1:0] RC_N =
        asc_pkg::CNT_W'(asc_pkg::RC_CYC);
    localparam logic [asc_pkg::CNT_W-1:0] SYNC_N = 5'h02;

    // Read data comes from a pin, so it is synchronised first
    asc_sync #(
        .WIDTH(DATA_W)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_data),
        .o_sync(data_sync)
    );

    // Sequencer for read and write cycles
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cyc = (cyc == 5'h1f) ? cyc : cyc + 5'h01;
        next_cs_n = cs_n;
        next_we_n = we_n;
        next_oe_n = oe_n;
        next_drive = drive;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        unique case (state)
            asc_pkg::ASC_IDLE: begin
                next_cs_n = 1'b1;
                next_we_n = 1'b1;
                next_oe_n = 1'b1;
                next_drive = 1'b0;
                if (i_req_valid) begin
                    // Address is set before select falls
                    next_addr = i_req_addr;
                    next_wdata = i_req_wdata;
                    next_cnt = '0;
                    next_cyc = '0;
                    next_state = i_req_write ? asc_pkg::ASC_WR_SETUP
                                             : asc_pkg::ASC_RD_ADDR;
                end
            end
            asc_pkg::ASC_RD_ADDR: begin
                // Select and gate fall with write strobe held high
                next_cs_n = 1'b0;
                next_oe_n = 1'b0;
                next_we_n = 1'b1;
                next_cnt = '0;
                next_state = asc_pkg::ASC_RD_WAIT;
            end
            asc_pkg::ASC_RD_WAIT: begin
                next_cnt = cnt + 5'h01;
                // Sample after access time plus synchroniser delay
                if (cnt == RD_N + SYNC_N - 5'h01) begin
                    next_rdata = data_sync;
                    next_rvalid = 1'b1;
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_cnt = '0;
                    next_state = asc_pkg::ASC_TURN;
                end
            end
            asc_pkg::ASC_WR_SETUP: begin
                // Gate high so the device floats before host drives
                next_oe_n = 1'b1;
                next_cs_n = 1'b0;
                next_we_n = 1'b0;
                next_drive = 1'b1;
                next_cnt = '0;
                next_state = asc_pkg::ASC_WR_PULSE;
            end
            asc_pkg::ASC_WR_PULSE: begin
                next_cnt = cnt + 5'h01;
                // Pulse covers strobe, select, address and data set-up
                if (cnt == WR_N - 5'h01) begin
                    next_we_n = 1'b1;
                    next_state = asc_pkg::ASC_WR_END;
                end
            end
            asc_pkg::ASC_WR_END: begin
                // Select rises a cycle after the strobe; data held
                next_cs_n = 1'b1;
                next_cnt = '0;
                next_state = asc_pkg::ASC_TURN;
            end
            asc_pkg::ASC_TURN: begin
                next_drive = 1'b0;
                next_cnt = cnt + 5'h01;
                // Allow bus turn-off and the least cycle time
                if (cnt >= HZ_N && cyc >= WC_N && cyc >= RC_N) begin
                    next_state = asc_pkg::ASC_IDLE;
                end
            end
            default: begin
                next_state = asc_pkg::ASC_IDLE;
            end
        endcase
    end

    // Register the sequencer state
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= asc_pkg::ASC_IDLE;
            cnt <= '0;
            cyc <= '0;
            cs_n <= asc_pkg::PIN_IDLE;
            we_n <= asc_pkg::PIN_IDLE;
            oe_n <= asc_pkg::PIN_IDLE;
            drive <= 1'b0;
            addr <= '0;
            wdata <= '0;
            rdata <= '0;
            rvalid <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cyc <= next_cyc;
            cs_n <= next_cs_n;
            we_n <= next_we_n;
            oe_n <= next_oe_n;
            drive <= next_drive;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // Pin and user outputs
    assign o_req_ready = (state == asc_pkg::ASC_IDLE);
    assign o_rd_valid = rvalid;
    assign o_rd_data = rdata;
    assign o_standby = cs_n;
    assign o_chip_select_n = cs_n;
    assign o_write_strobe_n = we_n;
    assign o_output_gate_n = oe_n;
    assign o_addr = addr;
    assign o_data = wdata;
    assign o_data_oe = drive;
endmodule

// ### dv/asc_monitor.sv
// Checker of the host's memory pin sequencing
module asc_monitor #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic o_chip_select_n,
    input wire logic o_write_strobe_n,
    input wire logic o_output_gate_n,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic [DATA_W-1:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_rd_valid
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_ws_in_cs: assert property (!o_write_strobe_n |-> !o_chip_select_n)
        else $error("write strobe low while deselected");
    a_cs_after_ws: assert property ($rose(o_write_strobe_n) |-> !o_chip_select_n)
        else $error("select rose with the strobe");
    a_no_clash: assert property (!o_output_gate_n |-> !o_data_oe)
        else $error("host drives data during a read");
    a_rd_ws_high: assert property (!o_output_gate_n |-> o_write_strobe_n)
        else $error("write strobe low during a read");
    a_addr_held: assert property (!o_chip_select_n |-> $stable(o_addr))
        else $error("address moved while selected");
    a_wr_data: assert property (!o_write_strobe_n |-> o_data_oe && $stable(o_data))
        else $error("write data not driven and stable");
    a_ws_width: assert property ($fell(o_write_strobe_n) |=> !o_write_strobe_n[*7])
        else $error("write strobe pulse too short");
    a_cs_cycle: assert property ($fell(o_chip_select_n) |=> !o_chip_select_n[*8])
        else $error("select cycle too short");
    a_rd_time: assert property ($fell(o_output_gate_n) |-> !o_rd_valid[*8] ##[1:5] o_rd_valid)
        else $error("read data returned at wrong time");
    c_read: cover property ($fell(o_output_gate_n));
    c_write: cover property ($fell(o_write_strobe_n));
    c_rd_done: cover property (o_rd_valid);
endmodule
bind asc_host asc_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_asc_monitor (.*);

// ### dv/asc_sram_model.sv
// Behavioural static memory on the far side of the host
module asc_sram_model #(
    parameter int AW = 19,
    parameter int DLY = 60
) (
    input wire logic i_cs_n,
    input wire logic i_ws_n,
    input wire logic i_og_n,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_host_data,
    input wire logic i_host_oe,
    output logic [7:0] o_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    logic [7:0] rd;
    logic [7:0] hold;
    logic drv;
    logic wr;
    // Drive only when selected with the gate open and no write; else float
    assign drv = !i_cs_n && i_ws_n && !i_og_n;
    assign wr = !i_cs_n && !i_ws_n;
    // Slow array access keeps old data past an address change
    assign #(DLY) rd = mem[i_addr[9:0]];
    // Store on whichever strobe ends the overlap
    always @(negedge wr) mem[i_addr[9:0]] = o_bus;
    // Wire level; a released bus shows the inverse of its last value
    always @* begin
        if (drv && i_host_oe) o_bus = 'x;
        else if (drv) o_bus = rd;
        else if (i_host_oe) o_bus = i_host_data;
        else o_bus = ~hold;
    end
    always @(o_bus) if (drv || i_host_oe) hold = o_bus;
endmodule

// ### dv/asc_host_tb_top.sv
// Testbench for the memory bus host
module asc_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_write = 0;
    logic [18:0] i_req_addr = '0;
    logic [7:0] i_req_wdata = '0, i_data, o_data, o_rd_data;
    logic o_req_ready, o_rd_valid, o_standby, o_data_oe;
    logic o_chip_select_n, o_write_strobe_n, o_output_gate_n;
    logic [18:0] o_addr, wa [0:7];
    logic [7:0] ref_mem [int], exp_q [$];
    int error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'h635c;
    always #4 i_ref_clk = ~i_ref_clk;
    asc_host i_asc_host (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_req_valid(i_req_valid), .i_req_write(i_req_write),
        .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_standby(o_standby),
        .o_chip_select_n(o_chip_select_n), .o_write_strobe_n(o_write_strobe_n),
        .o_output_gate_n(o_output_gate_n), .o_addr(o_addr), .i_data(i_data),
        .o_data(o_data), .o_data_oe(o_data_oe));
    asc_sram_model i_asc_sram_model (.i_cs_n(o_chip_select_n),
        .i_ws_n(o_write_strobe_n), .i_og_n(o_output_gate_n), .i_addr(o_addr),
        .i_host_data(o_data), .i_host_oe(o_data_oe), .o_bus(i_data));
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Wait for ready between edges, then present one request for one edge
    task automatic req(input logic w, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        do begin @(negedge i_ref_clk); n++; end while (!o_req_ready && n < 99);
        if (n >= 99) error_cnt++;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_write <= w;
        i_req_addr <= a;
        i_req_wdata <= d;
        if (w) ref_mem[a[9:0]] = d;
        else exp_q.push_back(ref_mem[a[9:0]]);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
    endtask
    // Read results are matched in order against the noted values
    always @(negedge i_ref_clk) if (o_rd_valid === 1'b1) begin
        if (exp_q.size() == 0) chk("rd_extra", 8'h01, 8'h00);
        else chk("rd_data", o_rd_data, exp_q.pop_front());
    end
    // Cut a hung run short
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 20000) begin error_cnt++; end_sim(); end
    end
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(negedge i_ref_clk);
        chk("cs_n_idle", {7'h0, o_chip_select_n}, 8'h01);
        chk("standby", {7'h0, o_standby}, 8'h01);
        // Back-to-back random writes, then read all back
        for (int i = 0; i < 8; i++) begin
            wa[i] = 19'($unsigned($random(seed)) & 32'h3ff);
            req(1'b1, wa[i], 8'($random(seed)));
        end
        for (int i = 0; i < 8; i++) req(1'b0, wa[i], 8'h00);
        // Overwrite one place twice and read it, then write and read another
        req(1'b1, wa[0], 8'h5a);
        req(1'b1, wa[0], 8'ha5);
        req(1'b0, wa[0], 8'h00);
        req(1'b1, wa[1], 8'h00);
        req(1'b0, wa[1], 8'h00);
        repeat (40) @(posedge i_ref_clk);
        chk("standby_end", {7'h0, o_standby}, 8'h01);
        chk("pending", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule
